// File: rtl/pad_decoder.sv
`timescale 1ns/100ps
module pad_decoder
  import pad_pkg::*;
(
  input  wire logic             I_CLK,
  input  wire logic             I_NRST,
  input  wire logic             I_CE,
  // Processor request
  input  wire logic             I_REQ,
  input  wire logic [40:0]      I_PA,
  input  pad_pkg::pad_acc_t     I_ACC,
  input  wire logic [3:0]       I_SIZE,
  input  wire logic             I_SPECIAL,
  input  wire logic             I_SEC_PRESENT,
  input  wire logic             I_SEC_SEL,
  // Inbound PCI address
  input  wire logic             I_PCI_REQ,
  input  wire logic [31:0]      I_PCI_ADDR,
  input  wire logic             I_PCI_IO,
  // Multi-function IO controller base pointers
  input  wire logic             I_BOOT_DONE,
  input  wire logic             I_BASE_WR,
  input  wire logic [1:0]       I_BASE_SEL,
  input  wire logic [31:0]      I_BASE_DATA,
  input  wire logic             I_LOC_REQ,
  input  wire logic [31:0]      I_LOC_ADDR,
  input  wire logic             I_LOC_WR,
  input  wire logic [3:0]       I_LOC_SIZE,
  output logic                  O_VALID,
  output pad_pkg::pad_tgt_t     O_TGT,
  output logic                  O_CACHEABLE,
  output pad_pkg::pad_cmd_t     O_CMD,
  output logic                  O_SEC_BUS,
  output logic                  O_ERR,
  output logic                  O_PCI_VALID,
  output pad_pkg::pad_psp_t     O_PCI_SPACE,
  output logic [7:0]            O_PCI_REG,
  output logic                  O_LOC_VALID,
  output logic [1:0]            O_LOC_HIT,
  output logic [31:0]           O_LOC_OFS,
  output logic                  O_LOC_ERR,
  output logic [40:0]           O_TRAP_PA,
  output logic [31:0]           O_TRAP_PCI,
  output logic [23:0]           O_TRAP_LEB
);
  import pad_pkg::*;

  // ************************************************************
  // Processor-side decode
  // ************************************************************
  function automatic logic in_rng(input logic [40:0] a, input logic [40:0] lo,
                                  input logic [40:0] hi);
    in_rng = (a >= lo) && (a <= hi);
  endfunction

  function automatic logic is_rd(input pad_acc_t a);
    is_rd = (a == ACC_RD) || (a == ACC_BRD) || (a == ACC_IFETCH);
  endfunction

  pad_tgt_t next_tgt;
  pad_cmd_t next_cmd;
  logic     next_err;

  always_comb begin
    next_tgt = TGT_NONE;
    next_cmd = CMD_NONE;
    next_err = 1'b0;
    // Narrow windows tested first so each address has one owner
    if (I_PA <= PA_MEM_LAST) begin
      next_tgt = TGT_MEM;
    end else if (in_rng(I_PA, PA_GFX_BASE, PA_GFX_LAST)) begin
      next_tgt = TGT_GFX;
    end else if (in_rng(I_PA, PA_IO_BASE, PA_CSR_LAST)) begin
      next_tgt = TGT_CSR;
    end else if (in_rng(I_PA, PA_CFG_BASE, PA_CFG_LAST)) begin
      if ((I_SIZE > 4'h4) || (I_ACC != ACC_RD && I_ACC != ACC_WR)) begin
        next_err = 1'b1;
      end else if (is_rd(I_ACC)) begin
        next_tgt = TGT_CFG;
        next_cmd = CMD_CFG_RD;
      end else begin
        next_tgt = TGT_CFG;
        next_cmd = I_SPECIAL ? CMD_SPECIAL : CMD_CFG_WR;
      end
    end else if (in_rng(I_PA, PA_PIO_BASE, PA_PIO_LAST)) begin
      if (I_ACC != ACC_RD && I_ACC != ACC_WR) begin
        next_err = 1'b1;
      end else begin
        next_tgt = TGT_PIO;
        next_cmd = is_rd(I_ACC) ? CMD_IO_RD : CMD_IO_WR;
      end
    end else if (in_rng(I_PA, PA_DNU_BASE, PA_DNU_LAST)) begin
      next_err = 1'b1;
    end else if (in_rng(I_PA, PA_IO_BASE, PA_PMEM_LAST)) begin
      // Single accesses are 4 or 8 bytes; block accesses carry a line
      if ((I_ACC == ACC_RD || I_ACC == ACC_WR || I_ACC == ACC_IFETCH) &&
          I_SIZE != 4'h4 && I_SIZE != 4'h8) begin
        next_err = 1'b1;
      end else begin
        next_tgt = TGT_PMEM;
        unique case (I_ACC)
          ACC_RD:     next_cmd = CMD_MEM_RD;
          ACC_IFETCH: next_cmd = CMD_MEM_RD_LINE;
          ACC_BRD:    next_cmd = CMD_MEM_RD_MUL;
          ACC_BWR:    next_cmd = CMD_MEM_WR;
          ACC_WR:     next_cmd = CMD_MEM_WR;
          default:    next_err = 1'b1;
        endcase
      end
    end else begin
      next_err = 1'b1;
    end
    if (next_err) begin
      next_tgt = TGT_ERR;
      next_cmd = CMD_NONE;
    end
  end

  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      O_VALID     <= 1'b0;
      O_TGT       <= TGT_NONE;
      O_CACHEABLE <= 1'b0;
      O_CMD       <= CMD_NONE;
      O_SEC_BUS   <= 1'b0;
      O_ERR       <= 1'b0;
    end else if (I_CE) begin
      O_VALID <= I_REQ;
      if (I_REQ) begin
        O_TGT       <= next_tgt;
        O_CACHEABLE <= (next_tgt == TGT_MEM);
        O_CMD       <= next_cmd;
        // Secondary bus only exists with the bridge fitted
        O_SEC_BUS   <= I_SEC_PRESENT && I_SEC_SEL &&
                       (next_tgt == TGT_CFG || next_tgt == TGT_PIO ||
                        next_tgt == TGT_PMEM);
        O_ERR       <= next_err;
      end
    end
  end

  // ************************************************************
  // Inbound PCI decode
  // ************************************************************
  pad_psp_t pci_space;

  pad_pci_split u_split (
    .i_addr  (I_PCI_ADDR),
    .i_is_io (I_PCI_IO),
    .o_space (pci_space)
  );

  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      O_PCI_VALID <= 1'b0;
      O_PCI_SPACE <= PSP_NONE;
      O_PCI_REG   <= 8'h00;
    end else if (I_CE) begin
      O_PCI_VALID <= I_PCI_REQ;
      if (I_PCI_REQ) begin
        O_PCI_SPACE <= pci_space;
        unique case (pci_space)
          PSP_DEV_VIRT_DMA:   O_PCI_REG <= DEV_VIRT_DMA_REG_VAL;
          PSP_A_MEM, PSP_A_IO: O_PCI_REG <= BUSA_REG_VAL;
          PSP_B_MEM, PSP_B_IO: O_PCI_REG <= BUSB_REG_VAL;
          default:            O_PCI_REG <= 8'h00;
        endcase
      end
    end
  end

  // ************************************************************
  // IO controller base pointers and local decode
  // ************************************************************
  // Bus A is left to firmware; only controller bases are held here
  logic [31:0] base [3];
  logic [1:0]  next_hit;
  logic [31:0] next_ofs;
  logic        next_lerr;

  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      for (int i = 0; i < 3; i++) begin
        base[i] <= 32'h0000_0000;
      end
    end else if (I_CE && I_BASE_WR && !I_BOOT_DONE && I_BASE_SEL != 2'h3) begin
      base[I_BASE_SEL] <= I_BASE_DATA;
    end
  end

  // Windows are 16 Mbyte aligned on each base; the lowest-numbered matching base wins
  always_comb begin
    next_hit  = 2'h3;
    next_ofs  = 32'h0000_0000;
    next_lerr = 1'b0;
    for (int i = 2; i >= 0; i--) begin
      if (I_LOC_ADDR[31:24] == base[i][31:24]) begin
        next_hit = 2'(i);
        next_ofs = {8'h00, I_LOC_ADDR[23:0]};
      end
    end
    if (next_hit == 2'h0) begin
      // PROM is read-only, byte or word, and holds 64 Kbytes
      next_lerr = I_LOC_WR || (I_LOC_SIZE != 4'h1 && I_LOC_SIZE != 4'h4) ||
                  (next_ofs[23:0] > PROM_LAST);
    end else if (next_hit == 2'h3) begin
      next_lerr = 1'b1;
    end
  end

  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      O_LOC_VALID <= 1'b0;
      O_LOC_HIT   <= 2'h3;
      O_LOC_OFS   <= 32'h0000_0000;
      O_LOC_ERR   <= 1'b0;
    end else if (I_CE) begin
      O_LOC_VALID <= I_LOC_REQ;
      if (I_LOC_REQ) begin
        O_LOC_HIT <= next_hit;
        O_LOC_OFS <= next_ofs;
        O_LOC_ERR <= next_lerr;
      end
    end
  end

  // ************************************************************
  // Strapped reset-trap addresses
  // ************************************************************
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      O_TRAP_PA  <= PA_RESET_TRAP;
      O_TRAP_PCI <= PCI_RESET_TRAP;
      O_TRAP_LEB <= LEB_RESET_TRAP;
    end else if (I_CE) begin
      O_TRAP_PA  <= PA_RESET_TRAP;
      O_TRAP_PCI <= PCI_RESET_TRAP;
      O_TRAP_LEB <= LEB_RESET_TRAP;
    end
  end
endmodule

// File: rtl/pad_pkg.sv
package pad_pkg;
  // ************************************************************
  // Processor physical address map
  // ************************************************************
  localparam int PA_W = 41;
  localparam int PCI_W = 32;
  localparam logic [40:0] PA_MEM_LAST = 41'h000_3FFF_FFFF;
  localparam logic [40:0] PA_GFX_BASE = 41'h1FC_0000_0000;
  localparam logic [40:0] PA_GFX_LAST = 41'h1FD_FFFF_FFFF;
  localparam logic [40:0] PA_IO_BASE = 41'h1FE_0000_0000;
  localparam logic [40:0] PA_CSR_LAST = 41'h1FE_0000_FFFF;
  localparam logic [40:0] PA_CFG_BASE = 41'h1FE_0100_0000;
  localparam logic [40:0] PA_CFG_LAST = 41'h1FE_01FF_FFFF;
  localparam logic [40:0] PA_PIO_BASE = 41'h1FE_0200_0000;
  localparam logic [40:0] PA_PIO_LAST = 41'h1FE_02FF_FFFF;
  localparam logic [40:0] PA_DNU_BASE = 41'h1FE_0300_0000;
  localparam logic [40:0] PA_DNU_LAST = 41'h1FE_FFFF_FFFF;
  localparam logic [40:0] PA_PMEM_LAST = 41'h1FF_FFFF_FFFF;
  // Strap is wider than PA[40:0]; bits above 40 are cut on purpose
  localparam logic [40:0] PA_RESET_TRAP = 41'(44'hFFF_F000_0000);
  // ************************************************************
  // PCI address map
  // ************************************************************
  localparam logic [31:0] PCI_A_MEM_BASE = 32'h4000_0000;
  localparam logic [31:0] PCI_DEV_VIRT_DMA_BASE = 32'h8000_0000;
  localparam logic [31:0] PCI_B_HI_BASE = 32'hC000_0000;
  localparam logic [31:0] PCI_A_IO_BASE = 32'h0040_0000;
  localparam logic [31:0] PCI_B_IO_HI = 32'h00C0_0000;
  localparam logic [31:0] PCI_RESET_TRAP = 32'hF000_0000;
  localparam logic [23:0] LEB_RESET_TRAP = 24'h00_0000;
  localparam logic [23:0] PROM_LAST = 24'h00_FFFF;
  localparam logic [7:0] DEV_VIRT_DMA_REG_VAL = 8'h30;
  localparam logic [7:0] BUSA_REG_VAL = 8'h0C;
  localparam logic [7:0] BUSB_REG_VAL = 8'hC3;

  typedef enum logic [2:0] {
    TGT_NONE, TGT_MEM, TGT_GFX, TGT_CSR, TGT_CFG, TGT_PIO, TGT_PMEM, TGT_ERR
  } pad_tgt_t;
  typedef enum logic [2:0] {
    ACC_RD, ACC_WR, ACC_BRD, ACC_BWR, ACC_IFETCH
  } pad_acc_t;
  typedef enum logic [3:0] {
    CMD_NONE = 4'h0, CMD_SPECIAL = 4'h1, CMD_IO_RD = 4'h2, CMD_IO_WR = 4'h3,
    CMD_MEM_RD = 4'h6, CMD_MEM_WR = 4'h7, CMD_CFG_RD = 4'hA, CMD_CFG_WR = 4'hB,
    CMD_MEM_RD_MUL = 4'hC, CMD_MEM_RD_LINE = 4'hE
  } pad_cmd_t;
  typedef enum logic [2:0] {
    PSP_NONE, PSP_DEV_VIRT_DMA, PSP_A_MEM, PSP_B_MEM, PSP_A_IO, PSP_B_IO
  } pad_psp_t;
endpackage

// File: rtl/pad_pci_split.sv
`timescale 1ns/100ps
// Splits an inbound PCI address into its owning window; pure logic.
module pad_pci_split
  import pad_pkg::*;
(
  input  wire logic [31:0] i_addr,
  input  wire logic        i_is_io,
  output pad_pkg::pad_psp_t o_space
);
  always_comb begin
    if (i_is_io) begin
      if (i_addr[31:24] != 8'h00) begin
        o_space = PSP_NONE;
      end else if (i_addr >= PCI_A_IO_BASE && i_addr < PCI_B_IO_HI) begin
        o_space = PSP_A_IO;
      end else begin
        o_space = PSP_B_IO;
      end
    end else if (i_addr >= PCI_DEV_VIRT_DMA_BASE && i_addr < PCI_B_HI_BASE) begin
      o_space = PSP_DEV_VIRT_DMA;
    end else if (i_addr >= PCI_A_MEM_BASE && i_addr < PCI_DEV_VIRT_DMA_BASE) begin
      o_space = PSP_A_MEM;
    end else begin
      o_space = PSP_B_MEM;
    end
  end
endmodule

// File: test/pad_decoder_monitor.sv
`timescale 1ns/100ps
module pad_decoder_chk
  import pad_pkg::*;
(
  input  wire logic         I_CLK,
  input  wire logic         I_NRST,
  input  wire logic         I_CE,
  input  wire logic         I_REQ,
  input  wire logic [40:0]  I_PA,
  input  pad_pkg::pad_acc_t I_ACC,
  input  wire logic [3:0]   I_SIZE,
  input  wire logic         I_PCI_REQ,
  input  wire logic [31:0]  I_PCI_ADDR,
  input  wire logic         I_PCI_IO,
  input  wire logic         O_VALID,
  input  pad_pkg::pad_tgt_t O_TGT,
  input  wire logic         O_CACHEABLE,
  input  pad_pkg::pad_cmd_t O_CMD,
  input  wire logic         O_SEC_BUS,
  input  wire logic         O_ERR,
  input  pad_pkg::pad_psp_t O_PCI_SPACE,
  input  wire logic [7:0]   O_PCI_REG,
  input  wire logic [40:0]  O_TRAP_PA,
  input  wire logic [31:0]  O_TRAP_PCI
);
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_NRST);
  logic p;
  logic cfg;
  assign p = I_REQ && I_CE;
  assign cfg = I_PA >= PA_CFG_BASE && I_PA <= PA_CFG_LAST;
  valid_follow_a: assert property (p |=> O_VALID)
    else $error("no valid after request");
  valid_cause_a: assert property ($rose(O_VALID) |-> $past(p))
    else $error("valid without request");
  mem_cache_a: assert property (p && I_PA <= PA_MEM_LAST |=> O_TGT == TGT_MEM && O_CACHEABLE)
    else $error("memory not cacheable");
  cache_mem_a: assert property (O_CACHEABLE |-> O_TGT == TGT_MEM)
    else $error("cacheable outside memory");
  cfg_read_a: assert property (p && cfg && I_ACC == ACC_RD && I_SIZE inside {[4'h1:4'h4]}
    |=> O_CMD == CMD_CFG_RD) else $error("config read command wrong");
  pio_write_a: assert property (p && I_PA >= PA_PIO_BASE && I_PA <= PA_PIO_LAST &&
    I_ACC == ACC_WR |=> O_TGT == TGT_PIO && O_CMD == CMD_IO_WR) else $error("io write wrong");
  dnu_err_a: assert property (p && I_PA >= PA_DNU_BASE && I_PA <= PA_DNU_LAST
    |=> O_ERR && O_CMD == CMD_NONE) else $error("unused range not refused");
  dev_dma_hit_a: assert property (I_PCI_REQ && I_CE && !I_PCI_IO &&
    I_PCI_ADDR[31:30] == 2'h2 |=> O_PCI_SPACE == PSP_DEV_VIRT_DMA &&
    O_PCI_REG == DEV_VIRT_DMA_REG_VAL) else $error("device dma window wrong");
  sec_only_pci_a: assert property (O_SEC_BUS |-> O_TGT inside {TGT_CFG, TGT_PIO, TGT_PMEM})
    else $error("secondary bus on non-pci target");
  trap_fixed_a: assert property (O_TRAP_PA == PA_RESET_TRAP && O_TRAP_PCI == PCI_RESET_TRAP)
    else $error("trap address moved");
endmodule
bind pad_decoder pad_decoder_chk i_chk (.*);

// File: test/pad_pci_far.sv
`timescale 1ns/100ps
module pad_pci_far (
  input  wire logic  i_clk,
  output logic       o_req,
  output logic [31:0] o_addr,
  output logic       o_io
);
  initial begin
    o_req = 1'h0;
    o_addr = 32'h0;
    o_io = 1'h0;
  end
  // Released lines show the inverse so a stale address never decodes by luck
  task automatic issue(input logic [31:0] a, input logic io);
    @(negedge i_clk);
    o_req = 1'h1;
    o_addr = a;
    o_io = io;
    @(negedge i_clk);
    o_req = 1'h0;
    o_addr = ~a;
    o_io = ~io;
  endtask
endmodule

// File: test/pad_decoder_test.sv
`timescale 1ns/100ps
module pad_decoder_test;
  import pad_pkg::*;
  logic        I_CLK = 1'h0;
  logic        I_NRST, I_CE, I_REQ, I_SPECIAL, I_SEC_PRESENT, I_SEC_SEL, I_PCI_REQ, I_PCI_IO;
  logic        I_BOOT_DONE, I_BASE_WR, I_LOC_REQ, I_LOC_WR, O_VALID, O_CACHEABLE, O_SEC_BUS;
  logic        O_ERR, O_PCI_VALID, O_LOC_VALID, O_LOC_ERR;
  logic [40:0] I_PA, O_TRAP_PA;
  logic [31:0] I_PCI_ADDR, I_BASE_DATA, I_LOC_ADDR, O_LOC_OFS, O_TRAP_PCI;
  logic [23:0] O_TRAP_LEB;
  logic [7:0]  O_PCI_REG;
  logic [3:0]  I_SIZE, I_LOC_SIZE;
  logic [1:0]  I_BASE_SEL, O_LOC_HIT;
  pad_acc_t    I_ACC;
  pad_tgt_t    O_TGT;
  pad_cmd_t    O_CMD;
  pad_psp_t    O_PCI_SPACE;
  logic [9:0]  qp[$];
  logic [11:0] qs[$];
  logic [34:0] ql[$];
  logic [34:0] le;
  logic [11:0] se;
  logic [31:0] seed = 32'hB1FA;
  int          n_errors = 0;
  int          total_checks = 0;

  pad_decoder i_dut (.*);
  pad_pci_far i_far (.i_clk(I_CLK), .o_req(I_PCI_REQ), .o_addr(I_PCI_ADDR), .o_io(I_PCI_IO));
  always #5 I_CLK = ~I_CLK;

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input string n, input logic [63:0] s, input logic [63:0] e);
    total_checks++;
    if (s !== e) begin
      n_errors++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic report_and_stop();
    if (n_errors == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // ************************************************************
  // Drivers: ps notes its expected answer before the request; pr and lr note theirs just after driving it
  // ************************************************************
  task automatic pr(input logic [40:0] a, input pad_acc_t c, input logic [3:0] z,
                    input pad_tgt_t t, input pad_cmd_t m);
    @(negedge I_CLK);
    I_REQ = 1'h1;
    I_PA = a;
    I_ACC = c;
    I_SIZE = z;
    I_SPECIAL = m == CMD_SPECIAL;
    qp.push_back({t, m, t == TGT_MEM, t == TGT_ERR,
                  I_SEC_PRESENT & I_SEC_SEL & (t inside {TGT_CFG, TGT_PIO, TGT_PMEM})});
  endtask
  task automatic ps(input logic [31:0] a, input logic io, input pad_psp_t s,
                    input logic [7:0] r, input logic c);
    qs.push_back({c, s, r});
    i_far.issue(a, io);
  endtask
  task automatic lr(input logic [31:0] a, input logic w, input logic [3:0] z,
                    input logic [1:0] h, input logic e);
    @(negedge I_CLK);
    I_LOC_REQ = 1'h1;
    I_LOC_ADDR = a;
    I_LOC_WR = w;
    I_LOC_SIZE = z;
    ql.push_back({h, ((h != 2'h3) ? {8'h0, a[23:0]} : 32'h0), e});
  endtask
  task automatic bw(input logic [1:0] s, input logic [31:0] d);
    @(negedge I_CLK);
    I_BASE_WR = 1'h1;
    I_BASE_SEL = s;
    I_BASE_DATA = d;
    @(negedge I_CLK);
    I_BASE_WR = 1'h0;
  endtask
  task automatic tbl();
    pr(41'h0, ACC_RD, 4'h8, TGT_MEM, CMD_NONE);
    pr(PA_MEM_LAST, ACC_WR, 4'h4, TGT_MEM, CMD_NONE);
    pr(41'h000_4000_0000, ACC_RD, 4'h4, TGT_ERR, CMD_NONE);
    pr(PA_GFX_LAST, ACC_WR, 4'h4, TGT_GFX, CMD_NONE);
    pr(PA_CSR_LAST, ACC_RD, 4'h4, TGT_CSR, CMD_NONE);
    pr(PA_CFG_BASE, ACC_RD, 4'h4, TGT_CFG, CMD_CFG_RD);
    pr(PA_CFG_LAST, ACC_WR, 4'h1, TGT_CFG, CMD_CFG_WR);
    pr(PA_CFG_BASE, ACC_WR, 4'h4, TGT_CFG, CMD_SPECIAL);
    pr(PA_CFG_BASE, ACC_RD, 4'h8, TGT_ERR, CMD_NONE);
    pr(PA_PIO_BASE | {9'h0, rnd() & 32'h00FF_FFFF}, ACC_RD, 4'h8, TGT_PIO, CMD_IO_RD);
    pr(PA_PIO_LAST, ACC_WR, 4'h2, TGT_PIO, CMD_IO_WR);
    pr(PA_DNU_BASE, ACC_RD, 4'h4, TGT_ERR, CMD_NONE);
    pr(PA_PMEM_LAST, ACC_RD, 4'h4, TGT_PMEM, CMD_MEM_RD);
    pr(41'h1FF_0000_0000, ACC_WR, 4'h8, TGT_PMEM, CMD_MEM_WR);
    pr(41'h1FF_0000_0040, ACC_BRD, 4'h2, TGT_PMEM, CMD_MEM_RD_MUL);
    pr(41'h1FF_0000_0080, ACC_BWR, 4'h8, TGT_PMEM, CMD_MEM_WR);
    pr(41'h1FF_0000_00C0, ACC_IFETCH, 4'h8, TGT_PMEM, CMD_MEM_RD_LINE);
    pr(41'h1FF_0000_0100, ACC_RD, 4'h2, TGT_ERR, CMD_NONE);
    @(negedge I_CLK);
    I_REQ = 1'h0;
  endtask
  // ************************************************************
  // Answer watcher
  // ************************************************************
  // Outputs settle at the rising edge, so they are read at the falling one
  always @(negedge I_CLK) begin
    if (O_VALID === 1'h1) begin
      if (qp.size() == 0) chk("proc_extra", 64'h1, 64'h0);
      else chk("proc", {O_TGT, O_CMD, O_CACHEABLE, O_ERR, O_SEC_BUS}, qp.pop_front());
    end
    if (O_PCI_VALID === 1'h1) begin
      if (qs.size() == 0) chk("pci_extra", 64'h1, 64'h0);
      else begin
        se = qs.pop_front();
        chk("pci", {se[11], O_PCI_SPACE, se[11] ? O_PCI_REG : 8'h0}, se);
      end
    end
    if (O_LOC_VALID === 1'h1) begin
      if (ql.size() == 0) chk("loc_extra", 64'h1, 64'h0);
      else begin
        le = ql.pop_front();
        chk("loc", {O_LOC_HIT, ((le[34:33] != 2'h3) ? O_LOC_OFS : 32'h0), O_LOC_ERR}, le);
      end
    end
  end
  // Run needs under 120 cycles; 2000 leaves a wide margin
  initial begin
    #20000;
    n_errors++;
    report_and_stop();
  end
  initial begin
    {I_NRST, I_REQ, I_SPECIAL, I_SEC_PRESENT, I_SEC_SEL, I_BOOT_DONE, I_BASE_WR} = '0;
    {I_LOC_REQ, I_LOC_WR, I_PA, I_SIZE, I_BASE_SEL, I_BASE_DATA, I_LOC_ADDR, I_LOC_SIZE} = '0;
    I_CE = 1'h1;
    I_ACC = ACC_RD;
    repeat (8) @(posedge I_CLK);
    chk("trap_pa", O_TRAP_PA, PA_RESET_TRAP);
    chk("trap_pci", O_TRAP_PCI, PCI_RESET_TRAP);
    chk("trap_leb", O_TRAP_LEB, LEB_RESET_TRAP);
    @(negedge I_CLK);
    I_NRST = 1'h1;
    for (int k = 0; k < 3; k++) begin
      I_SEC_PRESENT = k == 1;
      I_SEC_SEL = k != 0;
      tbl();
    end
    // Idle edge first, so the frozen edge finds valid already low
    @(negedge I_CLK);
    I_CE = 1'h0;
    I_REQ = 1'h1;
    @(negedge I_CLK);
    I_CE = 1'h1;
    I_REQ = 1'h0;
    ps(32'h8000_0000 | (rnd() & 32'h3FFF_FFFF), 1'h0, PSP_DEV_VIRT_DMA,
       DEV_VIRT_DMA_REG_VAL, 1'h1);
    ps(32'hBFFF_FFFF, 1'h0, PSP_DEV_VIRT_DMA, DEV_VIRT_DMA_REG_VAL, 1'h1);
    ps(32'h4000_0000, 1'h0, PSP_A_MEM, BUSA_REG_VAL, 1'h1);
    ps(32'h7FFF_FFFF, 1'h0, PSP_A_MEM, BUSA_REG_VAL, 1'h1);
    ps(32'h3FFF_FFFF, 1'h0, PSP_B_MEM, BUSB_REG_VAL, 1'h1);
    ps(32'hC000_0000, 1'h0, PSP_B_MEM, BUSB_REG_VAL, 1'h1);
    ps(32'h0040_0000, 1'h1, PSP_A_IO, BUSA_REG_VAL, 1'h1);
    ps(32'h007F_FFFF, 1'h1, PSP_A_IO, BUSA_REG_VAL, 1'h1);
    ps(32'h003F_FFFF, 1'h1, PSP_B_IO, BUSB_REG_VAL, 1'h1);
    ps(32'h00C0_0000, 1'h1, PSP_B_IO, BUSB_REG_VAL, 1'h1);
    ps(32'h0100_0000, 1'h1, PSP_NONE, 8'h00, 1'h1);
    bw(2'h0, 32'h0100_0000);
    bw(2'h1, 32'h0200_0000);
    bw(2'h2, 32'h0300_0000);
    bw(2'h3, 32'h0400_0000);
    I_BOOT_DONE = 1'h1;
    bw(2'h1, 32'h0500_0000);
    lr(32'h0100_1234, 1'h0, 4'h4, 2'h0, 1'h0);
    lr(32'h0100_FFFF, 1'h0, 4'h1, 2'h0, 1'h0);
    lr(32'h0101_0000, 1'h0, 4'h4, 2'h0, 1'h1);
    lr(32'h0100_0010, 1'h1, 4'h4, 2'h0, 1'h1);
    lr(32'h0100_0010, 1'h0, 4'h2, 2'h0, 1'h1);
    lr(32'h0200_0020, 1'h1, 4'h2, 2'h1, 1'h0);
    lr(32'h0300_0030, 1'h0, 4'h8, 2'h2, 1'h0);
    lr(32'h0400_0000, 1'h0, 4'h4, 2'h3, 1'h1);
    lr(32'h0500_0000, 1'h0, 4'h4, 2'h3, 1'h1);
    @(negedge I_CLK);
    I_LOC_REQ = 1'h0;
    repeat (3) @(negedge I_CLK);
    chk("trap_leb", O_TRAP_LEB, LEB_RESET_TRAP);
    chk("pending", qp.size() + qs.size() + ql.size(), 64'h0);
    report_and_stop();
  end
endmodule
